// [ieb_pkg.sv]
// package: register map, field positions, reset values and bus carrier for the enable bank
`default_nettype none

package ieb_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;

  // register indexes on the plain register port
  localparam logic [ADDR_W-1:0] OFS_ENABLE_1 = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_2 = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_STATUS_1 = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS_2 = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_MASK_1   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK_2   = 4'h5;

  // implemented bits; everything else writes nothing and reads zero
  localparam logic [DATA_W-1:0] IMPL_1 = 16'h000B;
  localparam logic [DATA_W-1:0] IMPL_2 = 16'hDFFF;
  localparam logic [DATA_W-1:0] RESET_VAL = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  // interrupt_enable_control_1 fields
  localparam int unsigned B1_I2C_A_SLAVE  = 0;
  localparam int unsigned B1_I2C_A_MASTER = 1;
  localparam int unsigned B1_UNUSED       = 2;
  localparam int unsigned B1_CHANGE_NOTE  = 3;

  // interrupt_enable_control_2 fields
  localparam int unsigned B2_SPI_B_ERROR  = 0;
  localparam int unsigned B2_SPI_B_EVENT  = 1;
  localparam int unsigned B2_CAN_A_RX     = 2;
  localparam int unsigned B2_CAN_A_EVENT  = 3;
  localparam int unsigned B2_DMA_THREE    = 4;
  localparam int unsigned B2_IN_CAP_THREE = 5;
  localparam int unsigned B2_IN_CAP_FOUR  = 6;
  localparam int unsigned B2_IN_CAP_FIVE  = 7;
  localparam int unsigned B2_IN_CAP_SIX   = 8;
  localparam int unsigned B2_OUT_CMP_FIVE = 9;
  localparam int unsigned B2_OUT_CMP_SIX  = 10;
  localparam int unsigned B2_OUT_CMP_SEVEN = 11;
  localparam int unsigned B2_OUT_CMP_EIGHT = 12;
  localparam int unsigned B2_UNUSED       = 13;
  localparam int unsigned B2_DMA_FOUR     = 14;
  localparam int unsigned B2_TIMER_SIX    = 15;

  // one register port access
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ieb_bus_s;

endpackage

`default_nettype wire

// [ieb_enable_reg.sv]
// module: one software enable register that stores only its implemented bits
`default_nettype none

module ieb_enable_reg
  import ieb_pkg::*;
#(
  parameter logic [DATA_W-1:0] IMPL  = 16'hFFFF,
  parameter logic [DATA_W-1:0] RST_V = 16'h0000
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wr_en,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] q
);

  logic [DATA_W-1:0] q_reg;

  // store a write; unimplemented positions always stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= RST_V & IMPL;
    end else if (wr_en) begin
      q_reg <= wdata & IMPL;
    end
  end

  assign q = q_reg;

endmodule

`default_nettype wire

// [ieb_sticky_bank.sv]
// module: sticky event status with write-one-to-clear, mask and level interrupt
`default_nettype none

module ieb_sticky_bank
  import ieb_pkg::*;
#(
  parameter logic [DATA_W-1:0] IMPL = 16'hFFFF
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [DATA_W-1:0] event_in,
  input  wire logic              clr_wr,
  input  wire logic              mask_wr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] status,
  output logic      [DATA_W-1:0] mask,
  output logic                   irq
);

  logic [DATA_W-1:0] status_reg;
  logic [DATA_W-1:0] status_next;
  logic [DATA_W-1:0] mask_reg;
  logic [DATA_W-1:0] clr_bits;

  // a new event in the clearing cycle wins over the clear
  always_comb begin
    clr_bits    = clr_wr ? wdata : ZERO_WORD;
    status_next = ((status_reg & ~clr_bits) | event_in) & IMPL;
  end

  // sticky status
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= RESET_VAL;
    end else begin
      status_reg <= status_next;
    end
  end

  // interrupt mask, same layout as status
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_reg <= RESET_VAL;
    end else if (mask_wr) begin
      mask_reg <= wdata & IMPL;
    end
  end

  assign status = status_reg;
  assign mask   = mask_reg;
  assign irq    = |(status_reg & mask_reg);

endmodule

`default_nettype wire

// [ieb_top.sv]
// module: interrupt enable bank that gates peripheral requests toward the interrupt logic
//
// What this block does
// - An implemented enable bit at one passes its source request on, at zero blocks it.
// - Bit 3 of the first enable register gates the change notification request.
// - Bit 2 of the first and bit 13 of the second register ignore writes and read zero.
// - Bit 1 of the first enable register gates the first I2C unit's master events.
// - Bit 0 of the first enable register gates the first I2C unit's slave events.
// - Bit 15 of the second enable register gates the sixth timer.
// - Bit 14 of the second enable register gates DMA channel 4 transfer complete.
// - Bits 12, 11, 10 and 9 of the second register gate output compare 8, 7, 6 and 5.
// - Bit 2 gates CAN receive ready, bit 1 the second SPI event, bit 0 its error.
//
// Implementation choices: strobed register access and the address map.
`default_nettype none

module ieb_top
  import ieb_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output logic      [DATA_W-1:0] REG_RDATA,
  input  wire logic [DATA_W-1:0] SRC_REQ_1,
  input  wire logic [DATA_W-1:0] SRC_REQ_2,
  output logic      [DATA_W-1:0] GATED_REQ_1,
  output logic      [DATA_W-1:0] GATED_REQ_2,
  output logic                   IRQ
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration check

  generate
    if (DATA_W != 16 || ADDR_W < 3) begin : g_bad_width
      $error("register port widths do not fit the enable bank");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // register port decode

  ieb_bus_s          bus;
  logic              wr_en_1;
  logic              wr_en_2;
  logic              wr_clr_1;
  logic              wr_clr_2;
  logic              wr_mask_1;
  logic              wr_mask_2;

  // pack the port into one carrier
  assign bus = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

  // write strobes per register
  assign wr_en_1   = bus.wr && (bus.addr == OFS_ENABLE_1);
  assign wr_en_2   = bus.wr && (bus.addr == OFS_ENABLE_2);
  assign wr_clr_1  = bus.wr && (bus.addr == OFS_STATUS_1);
  assign wr_clr_2  = bus.wr && (bus.addr == OFS_STATUS_2);
  assign wr_mask_1 = bus.wr && (bus.addr == OFS_MASK_1);
  assign wr_mask_2 = bus.wr && (bus.addr == OFS_MASK_2);

  ////////////////////////////////////////////////////////////////////////////////
  // enable registers

  logic [DATA_W-1:0] en_1;
  logic [DATA_W-1:0] en_2;

  // first enable register keeps bits 3, 1 and 0 only
  ieb_enable_reg #(
    .IMPL  (IMPL_1),
    .RST_V (RESET_VAL)
  ) u_enable_1 (
    .clk   (REF_CLK),
    .rst   (RST),
    .wr_en (wr_en_1),
    .wdata (bus.wdata),
    .q     (en_1)
  );

  // second enable register keeps all bits but 13
  ieb_enable_reg #(
    .IMPL  (IMPL_2),
    .RST_V (RESET_VAL)
  ) u_enable_2 (
    .clk   (REF_CLK),
    .rst   (RST),
    .wr_en (wr_en_2),
    .wdata (bus.wdata),
    .q     (en_2)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // request gating

  logic [DATA_W-1:0] gated_1_next;
  logic [DATA_W-1:0] gated_2_next;
  logic [DATA_W-1:0] gated_1_reg;
  logic [DATA_W-1:0] gated_2_reg;

  // each request passes only while its enable bit is one
  assign gated_1_next = SRC_REQ_1 & en_1;
  assign gated_2_next = SRC_REQ_2 & en_2;

  // registered requests toward the interrupt logic
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      gated_1_reg <= RESET_VAL;
      gated_2_reg <= RESET_VAL;
    end else begin
      gated_1_reg <= gated_1_next;
      gated_2_reg <= gated_2_next;
    end
  end

  assign GATED_REQ_1 = gated_1_reg;
  assign GATED_REQ_2 = gated_2_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // event status and interrupt

  logic [DATA_W-1:0] event_1;
  logic [DATA_W-1:0] event_2;
  logic [DATA_W-1:0] status_1;
  logic [DATA_W-1:0] status_2;
  logic [DATA_W-1:0] mask_1;
  logic [DATA_W-1:0] mask_2;
  logic              irq_1;
  logic              irq_2;

  // an event is a rising edge of a gated request
  assign event_1 = gated_1_next & ~gated_1_reg;
  assign event_2 = gated_2_next & ~gated_2_reg;

  // status and mask for the first register layout
  ieb_sticky_bank #(
    .IMPL    (IMPL_1)
  ) u_sticky_1 (
    .clk     (REF_CLK),
    .rst     (RST),
    .event_in(event_1),
    .clr_wr  (wr_clr_1),
    .mask_wr (wr_mask_1),
    .wdata   (bus.wdata),
    .status  (status_1),
    .mask    (mask_1),
    .irq     (irq_1)
  );

  // status and mask for the second register layout
  ieb_sticky_bank #(
    .IMPL    (IMPL_2)
  ) u_sticky_2 (
    .clk     (REF_CLK),
    .rst     (RST),
    .event_in(event_2),
    .clr_wr  (wr_clr_2),
    .mask_wr (wr_mask_2),
    .wdata   (bus.wdata),
    .status  (status_2),
    .mask    (mask_2),
    .irq     (irq_2)
  );

  assign IRQ = irq_1 | irq_2;

  ////////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the read strobe

  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] rdata_reg;

  // unmapped indexes and idle cycles read zero
  always_comb begin
    rdata_next = ZERO_WORD;
    if (bus.rd) begin
      case (bus.addr)
        OFS_ENABLE_1: rdata_next = en_1;
        OFS_ENABLE_2: rdata_next = en_2;
        OFS_STATUS_1: rdata_next = status_1;
        OFS_STATUS_2: rdata_next = status_2;
        OFS_MASK_1:   rdata_next = mask_1;
        OFS_MASK_2:   rdata_next = mask_2;
        default:      rdata_next = ZERO_WORD;
      endcase
    end
  end

  // read data register
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_reg <= RESET_VAL;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  // a set enable bit passes its request one cycle later
  a_pass_when_set: assert property (@(posedge REF_CLK) disable iff (RST)
    (SRC_REQ_2 != ZERO_WORD) |=> (GATED_REQ_2 == ($past(SRC_REQ_2) & $past(en_2))))
    else $error("gated requests of second bank do not follow enables");

  // an all-zero first enable register blocks every first request
  a_block_when_clear: assert property (@(posedge REF_CLK) disable iff (RST)
    (en_1 == ZERO_WORD) |=> (GATED_REQ_1 == ZERO_WORD))
    else $error("request passed while all first enables are zero");

  // change notification follows bit 3
  a_change_note_gate: assert property (@(posedge REF_CLK) disable iff (RST)
    (SRC_REQ_1[B1_CHANGE_NOTE] && en_1[B1_CHANGE_NOTE]) |=> GATED_REQ_1[B1_CHANGE_NOTE])
    else $error("change notification request not passed");

  // unimplemented enable bits read zero on any read of their register
  a_unused_read_zero: assert property (@(posedge REF_CLK) disable iff (RST)
    $past(bus.rd) |-> (!REG_RDATA[B1_UNUSED] || $past(bus.addr) != OFS_ENABLE_1)
      && (!REG_RDATA[B2_UNUSED] || $past(bus.addr) != OFS_ENABLE_2))
    else $error("unimplemented enable bit read back as one");

  // unimplemented positions never pass a request
  a_unused_no_pass: assert property (@(posedge REF_CLK) disable iff (RST)
    ##1 (!GATED_REQ_1[B1_UNUSED] && !GATED_REQ_2[B2_UNUSED]))
    else $error("unimplemented position passed a request");

  // master events of the first I2C unit follow bit 1
  a_i2c_master_gate: assert property (@(posedge REF_CLK) disable iff (RST)
    (!en_1[B1_I2C_A_MASTER]) |=> !GATED_REQ_1[B1_I2C_A_MASTER])
    else $error("I2C master request passed while disabled");

  // slave events of the first I2C unit follow bit 0
  a_i2c_slave_gate: assert property (@(posedge REF_CLK) disable iff (RST)
    (SRC_REQ_1[B1_I2C_A_SLAVE] && en_1[B1_I2C_A_SLAVE]) [*2] |=>
      GATED_REQ_1[B1_I2C_A_SLAVE] && $past(GATED_REQ_1[B1_I2C_A_SLAVE]))
    else $error("I2C slave request not held while enabled");

  // sixth timer follows bit 15, reached by a write to the second register
  a_timer_six_write: assert property (@(posedge REF_CLK) disable iff (RST)
    (wr_en_2 && bus.wdata[B2_TIMER_SIX]) ##1 SRC_REQ_2[B2_TIMER_SIX] |=>
      GATED_REQ_2[B2_TIMER_SIX])
    else $error("timer request not passed after enable write");

  // DMA channel 4 follows bit 14
  a_dma_four_gate: assert property (@(posedge REF_CLK) disable iff (RST)
    GATED_REQ_2[B2_DMA_FOUR] |-> $past(en_2[B2_DMA_FOUR] && SRC_REQ_2[B2_DMA_FOUR]))
    else $error("DMA four request without cause");

  // output compare 8 to 5 follow bits 12 to 9
  a_out_cmp_gate: assert property (@(posedge REF_CLK) disable iff (RST)
    ##1 GATED_REQ_2[B2_OUT_CMP_EIGHT:B2_OUT_CMP_FIVE] ==
      ($past(SRC_REQ_2[B2_OUT_CMP_EIGHT:B2_OUT_CMP_FIVE])
       & $past(en_2[B2_OUT_CMP_EIGHT:B2_OUT_CMP_FIVE])))
    else $error("output compare requests mis-gated");

  // capture, DMA three and CAN event follow bits 8 to 3
  a_capture_can_gate: assert property (@(posedge REF_CLK) disable iff (RST)
    ##1 GATED_REQ_2[B2_IN_CAP_SIX:B2_CAN_A_EVENT] ==
      ($past(SRC_REQ_2[B2_IN_CAP_SIX:B2_CAN_A_EVENT])
       & $past(en_2[B2_IN_CAP_SIX:B2_CAN_A_EVENT])))
    else $error("capture or CAN event requests mis-gated");

  // CAN receive and second SPI follow bits 2 to 0
  a_can_spi_gate: assert property (@(posedge REF_CLK) disable iff (RST)
    ##1 GATED_REQ_2[B2_CAN_A_RX:B2_SPI_B_ERROR] ==
      ($past(SRC_REQ_2[B2_CAN_A_RX:B2_SPI_B_ERROR])
       & $past(en_2[B2_CAN_A_RX:B2_SPI_B_ERROR])))
    else $error("CAN receive or SPI requests mis-gated");

  // a written enable reads back masked two cycles later
  a_enable_readback: assert property (@(posedge REF_CLK) disable iff (RST)
    (wr_en_2 ##1 (bus.rd && bus.addr == OFS_ENABLE_2 && !bus.wr)) |=>
      REG_RDATA == ($past(bus.wdata, 2) & IMPL_2))
    else $error("second enable register read back wrong");

  // interrupt level tracks unmasked status
  a_irq_level: assert property (@(posedge REF_CLK) disable iff (RST)
    IRQ == (|(status_1 & mask_1) || |(status_2 & mask_2)))
    else $error("interrupt level disagrees with status and mask");

  // an event in the clearing cycle survives the clear
  a_set_beats_clear: assert property (@(posedge REF_CLK) disable iff (RST)
    (wr_clr_2 && event_2[B2_TIMER_SIX]) |=> status_2[B2_TIMER_SIX])
    else $error("event lost under clear");

  c_timer_passed: cover property (@(posedge REF_CLK) disable iff (RST)
    wr_en_2 ##1 SRC_REQ_2[B2_TIMER_SIX] ##1 GATED_REQ_2[B2_TIMER_SIX]);

  c_irq_raised: cover property (@(posedge REF_CLK) disable iff (RST)
    $rose(IRQ));

  c_clear_race: cover property (@(posedge REF_CLK) disable iff (RST)
    wr_clr_1 && (event_1 != ZERO_WORD));

  c_back_to_back: cover property (@(posedge REF_CLK) disable iff (RST)
    bus.wr ##1 bus.rd);

endmodule

`default_nettype wire

// [ieb_tb_top.sv]
// testbench: self-checking bench for the interrupt enable bank with a cycle model
`default_nettype none

module ieb_tb_top
  import ieb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // implemented bits of both enable layouts, worked out independently of the design
  localparam logic [15:0] M1 = 16'h000B;
  localparam logic [15:0] M2 = 16'hDFFF;

  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] src1      = 16'h0000;
  logic [15:0] src2      = 16'h0000;
  wire  [15:0] rdata;
  wire  [15:0] gated1;
  wire  [15:0] gated2;
  wire         irq;
  logic [15:0] e1, e2, s1, s2, k1, k2, g1, g2, rdx;
  logic        chk_on = 1'b0;
  integer      seed = 33096;
  integer      n_mismatch = 0;
  integer      samples_checked = 0;

  ieb_top dut (
    .REF_CLK     (ref_clk),
    .RST         (rst),
    .REG_ADDR    (reg_addr),
    .REG_WDATA   (reg_wdata),
    .REG_WR      (reg_wr),
    .REG_RD      (reg_rd),
    .REG_RDATA   (rdata),
    .SRC_REQ_1   (src1),
    .SRC_REQ_2   (src2),
    .GATED_REQ_1 (gated1),
    .GATED_REQ_2 (gated2),
    .IRQ         (irq)
  );

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // reference model of the bank, stepped on the same edges as the design

  // new register value for a write at index a, limited to implemented bits
  function automatic logic [15:0] nxt(input logic [3:0] a, input logic [15:0] cur,
                                      input logic [15:0] m);
    return (reg_wr && reg_addr == a) ? (reg_wdata & m) : cur;
  endfunction

  // ones written to a status index clear those bits
  function automatic logic [15:0] clr(input logic [3:0] a);
    return (reg_wr && reg_addr == a) ? reg_wdata : 16'h0000;
  endfunction

  // read data for an index; unmapped indexes read zero
  function automatic logic [15:0] rmux(input logic [3:0] a);
    case (a)
      OFS_ENABLE_1: return e1;
      OFS_ENABLE_2: return e2;
      OFS_STATUS_1: return s1;
      OFS_STATUS_2: return s2;
      OFS_MASK_1:   return k1;
      OFS_MASK_2:   return k2;
      default:      return 16'h0000;
    endcase
  endfunction

  // model update; a new rising request wins over a clearing write
  always @(posedge ref_clk) begin
    if (rst) begin
      {e1, e2, s1, s2, k1, k2, g1, g2, rdx} <= '0;
    end else begin
      e1  <= nxt(OFS_ENABLE_1, e1, M1);
      e2  <= nxt(OFS_ENABLE_2, e2, M2);
      k1  <= nxt(OFS_MASK_1, k1, M1);
      k2  <= nxt(OFS_MASK_2, k2, M2);
      g1  <= src1 & e1;
      g2  <= src2 & e2;
      s1  <= ((s1 & ~clr(OFS_STATUS_1)) | (src1 & e1 & ~g1)) & M1;
      s2  <= ((s2 & ~clr(OFS_STATUS_2)) | (src2 & e2 & ~g2)) & M2;
      rdx <= reg_rd ? rmux(reg_addr) : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // comparison and reporting

  task automatic cmp16(input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic cmp1(input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // every cycle, mid-period, outputs against the model
  always @(negedge ref_clk) begin
    if (chk_on) begin
      cmp16(g1, gated1);
      cmp16(g2, gated2);
      cmp16(rdx, rdata);
      cmp1(|(s1 & k1) || |(s2 & k2), irq);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus driver: one register port cycle, all signals changed right after the edge

  task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    op(1'b1, 1'b0, a, d);
  endtask

  // read, then look at the data in the cycle after the read edge
  task automatic rreg(input logic [3:0] a, input logic [15:0] exp);
    op(1'b0, 1'b1, a, 16'h0000);
    op(1'b0, 1'b0, 4'h0, 16'h0000);
    #1;
    cmp16(exp, rdata);
  endtask

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    @(posedge ref_clk);
    chk_on <= 1'b1;
    repeat (19) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values read zero, unimplemented and unmapped places read zero
    for (int a = 0; a < 6; a++) begin
      rreg(a[3:0], 16'h0000);
    end
    wreg(OFS_ENABLE_1, 16'hFFFF);
    wreg(OFS_ENABLE_2, 16'hFFFF);
    wreg(4'h6, 16'hFFFF);
    rreg(OFS_ENABLE_1, M1);
    rreg(OFS_ENABLE_2, M2);
    rreg(4'h6, 16'h0000);
    rreg(4'hF, 16'h0000);
    // only the unimplemented bit written, read back with no gap
    wreg(OFS_ENABLE_2, 16'h2000);
    rreg(OFS_ENABLE_2, 16'h0000);
    // walk one enable bit at a time with every source requesting
    @(posedge ref_clk);
    src1 <= 16'hFFFF;
    src2 <= 16'hFFFF;
    for (int b = 0; b < 16; b++) begin
      wreg(OFS_ENABLE_2, 16'h0001 << b);
      wreg(OFS_ENABLE_1, 16'h0001 << (b % 4));
      op(1'b0, 1'b0, 4'h0, 16'h0000);
      op(1'b0, 1'b0, 4'h0, 16'h0000);
      #1;
      cmp16((16'h0001 << b) & M2, gated2);
      cmp16((16'h0001 << (b % 4)) & M1, gated1);
    end
    wreg(OFS_ENABLE_2, 16'h0000);
    wreg(OFS_ENABLE_1, 16'h0000);
    op(1'b0, 1'b0, 4'h0, 16'h0000);
    op(1'b0, 1'b0, 4'h0, 16'h0000);
    #1;
    cmp16(16'h0000, gated1 | gated2);
    // event, mask, clear, and an event landing on the clearing write
    wreg(OFS_ENABLE_2, 16'h8000);
    src2 <= 16'h0000;
    wreg(OFS_MASK_2, 16'h8000);
    wreg(OFS_STATUS_2, 16'hFFFF);
    wreg(OFS_STATUS_1, 16'hFFFF);
    op(1'b0, 1'b0, 4'h0, 16'h0000);
    src2 <= 16'h8000;
    op(1'b0, 1'b0, 4'h0, 16'h0000);
    #1;
    cmp1(1'b1, irq);
    wreg(OFS_STATUS_2, 16'h8000);
    op(1'b0, 1'b0, 4'h0, 16'h0000);
    src2 <= 16'h0000;
    #1;
    cmp1(1'b0, irq);
    wreg(OFS_STATUS_2, 16'h8000);
    src2 <= 16'h8000;
    op(1'b0, 1'b0, 4'h0, 16'h0000);
    #1;
    cmp1(1'b1, irq);
    wreg(OFS_MASK_2, 16'h0000);
    op(1'b0, 1'b0, 4'h0, 16'h0000);
    #1;
    cmp1(1'b0, irq);
    // random traffic on sources and register port, with one reset in mid-run
    for (int i = 0; i < 4000; i++) begin
      logic [31:0] r;
      logic [31:0] d;
      logic [31:0] s;
      r = $random(seed);
      d = $random(seed);
      s = $random(seed);
      op(r[1:0] == 2'd1, r[1:0] == 2'd2, {1'b0, r[4:2]}, d[15:0]);
      src1 <= s[15:0];
      src2 <= s[31:16];
      rst  <= (i >= 2000 && i < 2003);
    end
    op(1'b0, 1'b0, 4'h0, 16'h0000);
    repeat (3) @(posedge ref_clk);
    summarize();
  end

endmodule

`default_nettype wire
